//--- hdl/ctrb_top.v
// calibration vector port and factory trim register bank
`timescale 1ns/1ps
`default_nettype none
`include "ctrb_consts.vh"
// Operation
// - with port enabled, 673 successive reads return the whole calibration vector bytewise
// - 673 successive writes reload the saved vector into calibration state
// - a sequence ending before 673 accesses leaves calibration data invalid
// - channel A gain trim, 8-bit read-write at 0x07A, drives that channel
// - channel B gain trim, 8-bit read-write at 0x07B, drives that channel
// - reset loads factory trim values; software reads and overwrites them
// - reference trim in bits 3-0; bits 7-4 reserved read-write, reset 0000
// - first input termination trim, 8-bit read-write at 0x07E
// - second input termination trim, 8-bit read-write at 0x07F
// - sampling skew registers at 0x080 core A and 0x081 core B
// - core A skew register chosen by channel mode, background calibration and phase; core B always takes 0x081
// - bit 0 of 0x070 must be set for the vector port to work

module ctrb_top #(
	parameter [`CTRB_DW-1:0] FACTORY_GAIN_A = `CTRB_FACTORY_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_GAIN_B = `CTRB_FACTORY_DEFAULT,
	parameter [3:0] FACTORY_REF_V = `CTRB_FACTORY_REF_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_TERM_A = `CTRB_FACTORY_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_TERM_B = `CTRB_FACTORY_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_SKEW_A_FG90 = `CTRB_FACTORY_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_SKEW_B_FG0 = `CTRB_FACTORY_DEFAULT,
	parameter [`CTRB_DW-1:0] FACTORY_SKEW_A_BG90 = `CTRB_FACTORY_DEFAULT
) (
	// clock and reset
	input wire core_clk_i,
	input wire rst_b_i,
	// register port
	input wire [`CTRB_AW-1:0] reg_addr_i,
	input wire [`CTRB_DW-1:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [`CTRB_DW-1:0] reg_rdata_o,
	// calibration engine status and mode
	input wire calib_halted_flag_i,
	input wire single_channel_mode_i,
	input wire bg_cal_active_i,
	input wire bg_phase_90_i,
	// trim outputs
	output reg [`CTRB_DW-1:0] gain_adjust_a_o,
	output reg [`CTRB_DW-1:0] gain_adjust_b_o,
	output reg [3:0] reference_voltage_adjust_o,
	output reg [`CTRB_DW-1:0] termination_adjust_a_o,
	output reg [`CTRB_DW-1:0] termination_adjust_b_o,
	output reg [`CTRB_DW-1:0] core_a_skew_o,
	output reg [`CTRB_DW-1:0] core_b_skew_o,
	// calibration vector status
	output reg cal_valid_o,
	output reg cal_busy_o
);

	reg [`CTRB_DW-1:0] cal_en_reg;
	reg [3:0] ref_rsvd;
	reg [`CTRB_DW-1:0] skew_a_fg90;
	reg [`CTRB_DW-1:0] skew_b_fg0;
	reg [`CTRB_DW-1:0] skew_a_bg90;
	reg [`CTRB_IDX_W-1:0] vec_idx;
	reg corrupt;
	reg [`CTRB_DW-1:0] next_rdata;
	reg [`CTRB_DW-1:0] next_core_a_skew;
	wire [`CTRB_DW-1:0] store_rdata;
	wire port_en;
	wire vec_hit;
	wire vec_access;
	wire vec_last;
	wire vec_open;
	wire en_set;

	assign port_en = cal_en_reg[`CTRB_EN_BIT];
	assign vec_hit = (reg_addr_i == `CTRB_ADDR_CAL_VEC);
	// the port answers only while enabled and before the vector is exhausted
	assign vec_open = port_en && cal_busy_o;
	assign vec_access = vec_hit && (reg_wr_i || reg_rd_i) && vec_open;
	assign vec_last = (vec_idx == `CTRB_IDX_LAST);
	assign en_set = reg_wr_i && (reg_addr_i == `CTRB_ADDR_CAL_EN) && reg_wdata_i[`CTRB_EN_BIT];

	ctrb_vector_store u_store (
		.core_clk_i(core_clk_i),
		.idx_i(vec_idx),
		.we_i(vec_access && reg_wr_i),
		.wdata_i(reg_wdata_i),
		.rdata_o(store_rdata)
	);

	// byte index and sequence tracking
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			vec_idx <= `CTRB_IDX_ZERO;
			cal_busy_o <= 1'b0;
			cal_valid_o <= 1'b1;
			corrupt <= 1'b0;
		end else begin
			if (en_set) begin
				vec_idx <= `CTRB_IDX_ZERO;
				cal_busy_o <= 1'b1;
			end else if (vec_access) begin
				if (vec_last) begin
					vec_idx <= `CTRB_IDX_ZERO;
					cal_busy_o <= 1'b0;
				end else begin
					vec_idx <= vec_idx + `CTRB_IDX_ONE;
				end
			end else if (!port_en) begin
				cal_busy_o <= 1'b0;
			end
			// first access invalidates, the 673rd restores validity only if calibration is halted and corrupt is clear
			if (vec_access && vec_last && calib_halted_flag_i && !corrupt) begin
				cal_valid_o <= 1'b1;
			end else if (vec_access) begin
				cal_valid_o <= 1'b0;
			end
			// access during running calibration; set wins over clear
			if (vec_access && !calib_halted_flag_i) begin
				corrupt <= 1'b1;
			end else if (en_set) begin
				corrupt <= 1'b0;
			end else if (reg_wr_i && (reg_addr_i == `CTRB_ADDR_CAL_STAT)
				&& reg_wdata_i[`CTRB_STAT_CORRUPT_BIT]) begin
				corrupt <= 1'b0;
			end
		end
	end

	// register writes
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_en_reg <= `CTRB_BYTE_ZERO;
			gain_adjust_a_o <= FACTORY_GAIN_A;
			gain_adjust_b_o <= FACTORY_GAIN_B;
			reference_voltage_adjust_o <= FACTORY_REF_V;
			ref_rsvd <= `CTRB_NIB_ZERO;
			termination_adjust_a_o <= FACTORY_TERM_A;
			termination_adjust_b_o <= FACTORY_TERM_B;
			skew_a_fg90 <= FACTORY_SKEW_A_FG90;
			skew_b_fg0 <= FACTORY_SKEW_B_FG0;
			skew_a_bg90 <= FACTORY_SKEW_A_BG90;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`CTRB_ADDR_CAL_EN: begin
					cal_en_reg <= reg_wdata_i;
				end
				`CTRB_ADDR_GAIN_A: begin
					gain_adjust_a_o <= reg_wdata_i;
				end
				`CTRB_ADDR_GAIN_B: begin
					gain_adjust_b_o <= reg_wdata_i;
				end
				`CTRB_ADDR_REF_V: begin
					reference_voltage_adjust_o <= reg_wdata_i[`CTRB_REF_TRIM_MSB:0];
					ref_rsvd <= reg_wdata_i[`CTRB_REF_RSVD_MSB:`CTRB_REF_RSVD_LSB];
				end
				`CTRB_ADDR_TERM_A: begin
					termination_adjust_a_o <= reg_wdata_i;
				end
				`CTRB_ADDR_TERM_B: begin
					termination_adjust_b_o <= reg_wdata_i;
				end
				`CTRB_ADDR_SKEW_A_FG90: begin
					skew_a_fg90 <= reg_wdata_i;
				end
				`CTRB_ADDR_SKEW_B_FG0: begin
					skew_b_fg0 <= reg_wdata_i;
				end
				`CTRB_ADDR_SKEW_A_BG90: begin
					skew_a_bg90 <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// skew selection per core
	always @* begin
		next_core_a_skew = skew_a_fg90;
		if (single_channel_mode_i && bg_cal_active_i && bg_phase_90_i) begin
			next_core_a_skew = skew_a_bg90;
		end
	end

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			core_a_skew_o <= FACTORY_SKEW_A_FG90;
			core_b_skew_o <= FACTORY_SKEW_B_FG0;
		end else begin
			core_a_skew_o <= next_core_a_skew;
			core_b_skew_o <= skew_b_fg0;
		end
	end

	// read mux
	always @* begin
		next_rdata = `CTRB_BYTE_ZERO;
		case (reg_addr_i)
			`CTRB_ADDR_CAL_EN: next_rdata = cal_en_reg;
			`CTRB_ADDR_CAL_VEC: next_rdata = vec_open ? store_rdata : `CTRB_BYTE_ZERO;
			`CTRB_ADDR_CAL_STAT: begin
				next_rdata[`CTRB_STAT_VALID_BIT] = cal_valid_o;
				next_rdata[`CTRB_STAT_CORRUPT_BIT] = corrupt;
				next_rdata[`CTRB_STAT_BUSY_BIT] = cal_busy_o;
			end
			`CTRB_ADDR_IDX_LO: next_rdata = vec_idx[`CTRB_DW-1:0];
			`CTRB_ADDR_IDX_HI: next_rdata = {6'h00, vec_idx[`CTRB_IDX_W-1:`CTRB_DW]};
			`CTRB_ADDR_GAIN_A: next_rdata = gain_adjust_a_o;
			`CTRB_ADDR_GAIN_B: next_rdata = gain_adjust_b_o;
			`CTRB_ADDR_REF_V: next_rdata = {ref_rsvd, reference_voltage_adjust_o};
			`CTRB_ADDR_TERM_A: next_rdata = termination_adjust_a_o;
			`CTRB_ADDR_TERM_B: next_rdata = termination_adjust_b_o;
			`CTRB_ADDR_SKEW_A_FG90: next_rdata = skew_a_fg90;
			`CTRB_ADDR_SKEW_B_FG0: next_rdata = skew_b_fg0;
			`CTRB_ADDR_SKEW_A_BG90: next_rdata = skew_a_bg90;
			default: next_rdata = `CTRB_BYTE_ZERO;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= `CTRB_BYTE_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= `CTRB_BYTE_ZERO;
		end
	end

endmodule // ctrb_top

`default_nettype wire

//--- hdl/ctrb_consts.vh
// constants for the calibration and trim register bank
`ifndef CTRB_CONSTS_VH
`define CTRB_CONSTS_VH

// register port widths
`define CTRB_AW 12
`define CTRB_DW 8

// register offsets
`define CTRB_ADDR_CAL_EN 12'h070
`define CTRB_ADDR_CAL_VEC 12'h071
`define CTRB_ADDR_CAL_STAT 12'h072
`define CTRB_ADDR_IDX_LO 12'h073
`define CTRB_ADDR_IDX_HI 12'h074
`define CTRB_ADDR_GAIN_A 12'h07A
`define CTRB_ADDR_GAIN_B 12'h07B
`define CTRB_ADDR_REF_V 12'h07C
`define CTRB_ADDR_TERM_A 12'h07E
`define CTRB_ADDR_TERM_B 12'h07F
`define CTRB_ADDR_SKEW_A_FG90 12'h080
`define CTRB_ADDR_SKEW_B_FG0 12'h081
`define CTRB_ADDR_SKEW_A_BG90 12'h082

// field positions
`define CTRB_EN_BIT 0
`define CTRB_STAT_VALID_BIT 0
`define CTRB_STAT_CORRUPT_BIT 1
`define CTRB_STAT_BUSY_BIT 2
`define CTRB_REF_TRIM_MSB 3
`define CTRB_REF_RSVD_MSB 7
`define CTRB_REF_RSVD_LSB 4

// calibration vector
`define CTRB_VEC_LEN 673
`define CTRB_IDX_W 10
`define CTRB_IDX_LAST 10'h2A0
`define CTRB_IDX_ZERO 10'h000
`define CTRB_IDX_ONE 10'h001

// reset values
`define CTRB_BYTE_ZERO 8'h00
`define CTRB_NIB_ZERO 4'h0
`define CTRB_FACTORY_DEFAULT 8'h80
`define CTRB_FACTORY_REF_DEFAULT 4'h8

`endif

//--- hdl/ctrb_vector_store.v
// calibration vector storage, one byte per index
`timescale 1ns/1ps
`default_nettype none
`include "ctrb_consts.vh"

module ctrb_vector_store (
	// clock
	input wire core_clk_i,
	// byte access
	input wire [`CTRB_IDX_W-1:0] idx_i,
	input wire we_i,
	input wire [`CTRB_DW-1:0] wdata_i,
	output wire [`CTRB_DW-1:0] rdata_o
);

	reg [`CTRB_DW-1:0] mem [0:`CTRB_VEC_LEN-1];

	// combinational read; the top registers it
	assign rdata_o = mem[idx_i];

	always @(posedge core_clk_i) begin
		if (we_i) begin
			mem[idx_i] <= wdata_i;
		end
	end

endmodule // ctrb_vector_store

`default_nettype wire

//--- bench/ctrb_monitor.sv
// assertion checker for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module ctrb_monitor (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] gain_adjust_a_o,
	input wire logic [3:0] reference_voltage_adjust_o,
	input wire logic [7:0] termination_adjust_a_o,
	input wire logic [7:0] core_b_skew_o,
	input wire logic cal_valid_o,
	input wire logic cal_busy_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	gain_a_write_a: assert property (reg_wr_i && reg_addr_i == 12'h07A |=>
		gain_adjust_a_o == $past(reg_wdata_i)) else $error("gain a write lost");
	ref_trim_write_a: assert property (reg_wr_i && reg_addr_i == 12'h07C |=>
		reference_voltage_adjust_o == $past(reg_wdata_i[3:0])) else $error("ref trim lost");
	term_a_write_a: assert property (reg_wr_i && reg_addr_i == 12'h07E |=>
		termination_adjust_a_o == $past(reg_wdata_i)) else $error("term a write lost");
	skew_b_follow_a: assert property (reg_wr_i && reg_addr_i == 12'h081 |=> ##1
		core_b_skew_o == $past(reg_wdata_i, 2)) else $error("core b skew wrong");
	gain_readback_a: assert property (reg_rd_i && reg_addr_i == 12'h07A |=>
		reg_rdata_o == gain_adjust_a_o) else $error("gain a readback wrong");
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	busy_open_a: assert property (reg_wr_i && reg_addr_i == 12'h070 && reg_wdata_i[0]
		|=> cal_busy_o) else $error("sequence not opened");
	valid_close_a: assert property ($rose(cal_valid_o) |-> $fell(cal_busy_o))
		else $error("valid rose outside completion");
endmodule // ctrb_monitor
bind ctrb_top ctrb_monitor u_mon (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gain_adjust_a_o(gain_adjust_a_o),
	.reference_voltage_adjust_o(reference_voltage_adjust_o),
	.termination_adjust_a_o(termination_adjust_a_o), .core_b_skew_o(core_b_skew_o),
	.cal_valid_o(cal_valid_o), .cal_busy_o(cal_busy_o));
`default_nettype wire

//--- bench/test_ctrb_top.sv
// self-checking bench for the trim register bank
`timescale 1ns/1ps
`default_nettype none
`include "ctrb_consts.vh"
module test_ctrb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic halt = 1'b1;
	logic sc = 1'b0;
	logic bg = 1'b0;
	logic ph = 1'b0;
	wire [7:0] rdata, ga, gb, ta, tb, ska, skb;
	wire [3:0] rv;
	wire valid, busy;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [11:0] am [7] = '{12'h07A, 12'h07B, 12'h07C, 12'h07E, 12'h07F, 12'h080, 12'h081};
	ctrb_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .calib_halted_flag_i(halt),
		.single_channel_mode_i(sc), .bg_cal_active_i(bg), .bg_phase_90_i(ph),
		.gain_adjust_a_o(ga), .gain_adjust_b_o(gb), .reference_voltage_adjust_o(rv),
		.termination_adjust_a_o(ta), .termination_adjust_b_o(tb), .core_a_skew_o(ska),
		.core_b_skew_o(skb), .cal_valid_o(valid), .cal_busy_o(busy));
	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wreg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [11:0] a, output logic [7:0] q);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] q;
		rreg(a, q);
		chk("reg read", q, e);
	endtask
	// 673 port accesses; byte bad is taken while calibration runs
	task automatic vseq(input logic w, input int bad, input logic cmp);
		logic [7:0] q;
		for (int i = 0; i < `CTRB_VEC_LEN; i++) begin
			halt <= (i != bad);
			if (w) wreg(12'h071, i[7:0] ^ 8'h5A);
			else begin
				rreg(12'h071, q);
				if (cmp) chk("vector byte", q, i[7:0] ^ 8'h5A);
			end
		end
		halt <= 1'b1;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 7; i++) rchk(am[i], (i == 2) ? 8'h08 : 8'h80);
		chk("skew a", ska, 8'h80);
		chk("valid", {7'h00, valid}, 8'h01);
	endtask
	task automatic t_trim();
		for (int i = 0; i < 7; i++) wreg(am[i], 8'hA0 + i[7:0]);
		for (int i = 0; i < 7; i++) rchk(am[i], 8'hA0 + i[7:0]);
		chk("gain a", ga, 8'hA0);
		chk("gain b", gb, 8'hA1);
		chk("ref", {4'h0, rv}, 8'h02);
		chk("term a", ta, 8'hA3);
		chk("term b", tb, 8'hA4);
		chk("skew b", skb, 8'hA6);
		wreg(12'h07D, 8'hFF);
		rchk(12'h07D, 8'h00);
	endtask
	task automatic t_skew();
		wreg(12'h080, 8'h11);
		wreg(12'h082, 8'h22);
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			{sc, bg, ph} <= k[2:0];
			repeat (2) @(posedge clk);
			#1 chk("skew a", ska, (k == 7) ? 8'h22 : 8'h11);
		end
	endtask
	task automatic t_vec();
		wreg(12'h070, 8'h01);
		#1 chk("busy", {7'h00, busy}, 8'h01);
		vseq(1'b1, -1, 1'b0);
		#1 chk("valid", {6'h00, valid, busy}, 8'h02);
		wreg(12'h070, 8'h01);
		vseq(1'b0, -1, 1'b1);
		#1 chk("valid", {6'h00, valid, busy}, 8'h02);
	endtask
	task automatic t_short();
		wreg(12'h070, 8'h01);
		for (int i = 0; i < 10; i++) wreg(12'h071, 8'h33);
		wreg(12'h070, 8'h00);
		// busy drops one cycle after the enable bit clears
		@(posedge clk);
		#1 chk("valid", {6'h00, valid, busy}, 8'h00);
		rchk(12'h071, 8'h00);
		wreg(12'h070, 8'h01);
		vseq(1'b0, 300, 1'b0);
		#1 chk("valid", {7'h00, valid}, 8'h00);
		rchk(12'h072, 8'h02);
		wreg(12'h070, 8'h01);
		vseq(1'b0, -1, 1'b0);
		#1 chk("valid", {7'h00, valid}, 8'h01);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_trim();
		t_skew();
		t_vec();
		t_short();
		results();
	end
endmodule // test_ctrb_top
`default_nettype wire
